// ### verilog/spsf_regs.sv
// axi4-lite register bank for switch port status and counter overflow flags
`timescale 1ns/1ps
module spsf_regs
(
   // clock and reset
   input  wire logic                 mclk_i,
   input  wire logic                 reset_n_i,
   // port status from link and cable-test logic
   input  wire spsf_pkg::spsf_port_t ports_i [6],
   // one-cycle pulses, counter wrapping to zero
   input  wire spsf_pkg::spsf_wrap_t wrap_i,
   // axi4-lite write address and data
   input  wire logic [8:0]           s_axi_awaddr_i,
   input  wire logic                 s_axi_awvalid_i,
   output logic                      s_axi_awready_o,
   input  wire logic [31:0]          s_axi_wdata_i,
   input  wire logic [3:0]           s_axi_wstrb_i,
   input  wire logic                 s_axi_wvalid_i,
   output logic                      s_axi_wready_o,
   // axi4-lite write response
   output logic [1:0]                s_axi_bresp_o,
   output logic                      s_axi_bvalid_o,
   input  wire logic                 s_axi_bready_i,
   // axi4-lite read
   input  wire logic [8:0]           s_axi_araddr_i,
   input  wire logic                 s_axi_arvalid_i,
   output logic                      s_axi_arready_o,
   output logic [31:0]               s_axi_rdata_o,
   output logic [1:0]                s_axi_rresp_o,
   output logic                      s_axi_rvalid_o,
   input  wire logic                 s_axi_rready_i,
   // interrupt
   output logic                      irq_o
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   spsf_pkg::spsf_port_t status_reg [6];
   logic [31:0]          rx_ovf_reg;
   logic [31:0]          tx_ovf_reg;
   logic [31:0]          rx_ovf_next;
   logic [31:0]          tx_ovf_next;
   logic [spsf_pkg::IRQ_BITS-1:0] irq_status_reg;
   logic [spsf_pkg::IRQ_BITS-1:0] irq_status_next;
   logic [spsf_pkg::IRQ_BITS-1:0] irq_mask_reg;
   logic [spsf_pkg::IRQ_BITS-1:0] irq_event;
   logic                 aw_held_reg;
   logic                 w_held_reg;
   logic [6:0]           aw_idx_reg;
   logic [31:0]          wdata_reg;
   logic [3:0]           wstrb_reg;
   logic                 bvalid_reg;
   logic [1:0]           bresp_reg;
   logic                 rvalid_reg;
   logic [1:0]           rresp_reg;
   logic [31:0]          rdata_reg;
   logic [6:0]           rd_idx_reg;
   logic [31:0]          port04_word;
   logic [31:0]          port5_word;
   logic [31:0]          cable_word;
   logic [31:0]          rd_word;
   logic                 rd_hit;
   logic                 ar_take;
   logic [6:0]           ar_idx;
   logic                 wr_go;
   logic [31:0]          rx_set;
   logic [31:0]          tx_set;
   logic                 link_chg;
   logic                 cable_rise;

   // ------------------------------------------------------------
   // status sampling
   // ------------------------------------------------------------
   // inputs are flopped for read data; edge detects compare the raw input against the flopped copy
   always_ff @(posedge mclk_i)
   begin
      for (int p = 0; p < spsf_pkg::NUM_PORTS; p++)
      begin
         if (!reset_n_i)
            status_reg[p] <= '0;
         else
            status_reg[p] <= ports_i[p];
      end
   end

   // status words assembled from the sampled port state
   always_comb
   begin
      port04_word = spsf_pkg::RESET_WORD;
      cable_word  = spsf_pkg::RESET_WORD;
      port5_word  = spsf_pkg::RESET_WORD;
      for (int p = 0; p < 5; p++)
      begin
         port04_word[spsf_pkg::PORT_BASE[p] + spsf_pkg::LINK_OFS]   = status_reg[p].link;
         port04_word[spsf_pkg::PORT_BASE[p] + spsf_pkg::SPEED_OFS]  = status_reg[p].speed;
         port04_word[spsf_pkg::PORT_BASE[p] + spsf_pkg::DUPLEX_OFS] = status_reg[p].duplex;
         port04_word[spsf_pkg::PORT_BASE[p] + spsf_pkg::FLOW_OFS]   = status_reg[p].flow;
         cable_word[spsf_pkg::BROKEN_POS[p]] = status_reg[p].broken;
         cable_word[spsf_pkg::LEN_LSB[p] +: 2] = status_reg[p].break_len;
      end
      // port 5 flags, upper bits stay zero
      port5_word[spsf_pkg::P5_LINK_POS]   = status_reg[5].link;
      port5_word[spsf_pkg::P5_DUPLEX_POS] = status_reg[5].duplex;
      port5_word[spsf_pkg::P5_FLOW_POS]   = status_reg[5].flow;
      port5_word[spsf_pkg::P5_SPEED_LSB +: 2] = {1'b0, status_reg[5].speed};
   end

   // ------------------------------------------------------------
   // overflow flags
   // ------------------------------------------------------------
   always_comb
   begin
      rx_set = '0;
      tx_set = '0;
      for (int p = 0; p < spsf_pkg::NUM_PORTS; p++)
      begin
         rx_set[spsf_pkg::OVF_PKT_POS[p]]  = wrap_i.rx_pkt[p];
         rx_set[spsf_pkg::OVF_BYTE_POS[p]] = wrap_i.rx_byte[p];
         tx_set[spsf_pkg::OVF_PKT_POS[p]]  = wrap_i.tx_pkt[p];
         tx_set[spsf_pkg::OVF_BYTE_POS[p]] = wrap_i.tx_byte[p];
      end
   end

   // clear on read, a wrap in that cycle still wins
   always_comb
   begin
      rx_ovf_next = rx_ovf_reg;
      tx_ovf_next = tx_ovf_reg;
      if (ar_take && ar_idx == spsf_pkg::IDX_RX_COUNTER_OVF)
         rx_ovf_next = '0;
      if (ar_take && ar_idx == spsf_pkg::IDX_TX_COUNTER_OVF)
         tx_ovf_next = '0;
      rx_ovf_next = rx_ovf_next | rx_set;
      tx_ovf_next = tx_ovf_next | tx_set;
   end

   // latch taken at the wrap edge itself
   always_ff @(posedge mclk_i)
   begin
      if (!reset_n_i)
      begin
         rx_ovf_reg <= spsf_pkg::RESET_WORD;
         tx_ovf_reg <= spsf_pkg::RESET_WORD;
      end
      else
      begin
         rx_ovf_reg <= rx_ovf_next;
         tx_ovf_reg <= tx_ovf_next;
      end
   end

   // ------------------------------------------------------------
   // interrupts
   // ------------------------------------------------------------
   always_comb
   begin
      link_chg   = 1'b0;
      cable_rise = 1'b0;
      for (int p = 0; p < spsf_pkg::NUM_PORTS; p++)
         link_chg = link_chg | (ports_i[p].link ^ status_reg[p].link);
      for (int p = 0; p < spsf_pkg::NUM_CABLE; p++)
         cable_rise = cable_rise | (ports_i[p].broken & ~status_reg[p].broken);
      irq_event = '0;
      irq_event[spsf_pkg::IRQ_RX_OVF] = |rx_set;
      irq_event[spsf_pkg::IRQ_TX_OVF] = |tx_set;
      irq_event[spsf_pkg::IRQ_CABLE]  = cable_rise;
      irq_event[spsf_pkg::IRQ_LINK]   = link_chg;
      irq_status_next = irq_status_reg;
      if (ar_take && ar_idx == spsf_pkg::IDX_IRQ_STATUS)
         irq_status_next = '0;
      irq_status_next = irq_status_next | irq_event;
   end

   // sticky status, cleared by its read; set beats clear
   always_ff @(posedge mclk_i)
   begin
      if (!reset_n_i)
         irq_status_reg <= '0;
      else
         irq_status_reg <= irq_status_next;
   end

   // mask register, the only writable state
   always_ff @(posedge mclk_i)
   begin
      if (!reset_n_i)
         irq_mask_reg <= '0;
      else if (wr_go && aw_idx_reg == spsf_pkg::IDX_IRQ_MASK && wstrb_reg[0])
         irq_mask_reg <= wdata_reg[spsf_pkg::IRQ_BITS-1:0];
   end

   assign irq_o = |(irq_status_reg & irq_mask_reg);

   // ------------------------------------------------------------
   // axi4-lite write path
   // ------------------------------------------------------------
   // address and data taken in either order, one write at a time
   assign s_axi_awready_o = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready_o  = !w_held_reg && !bvalid_reg;
   assign wr_go           = aw_held_reg && w_held_reg && !bvalid_reg;

   always_ff @(posedge mclk_i)
   begin
      if (!reset_n_i)
      begin
         aw_held_reg <= 1'b0;
         aw_idx_reg  <= '0;
      end
      else if (s_axi_awvalid_i && s_axi_awready_o)
      begin
         aw_held_reg <= 1'b1;
         aw_idx_reg  <= s_axi_awaddr_i[8:2];
      end
      else if (wr_go)
         aw_held_reg <= 1'b0;
   end

   always_ff @(posedge mclk_i)
   begin
      if (!reset_n_i)
      begin
         w_held_reg <= 1'b0;
         wdata_reg  <= '0;
         wstrb_reg  <= '0;
      end
      else if (s_axi_wvalid_i && s_axi_wready_o)
      begin
         w_held_reg <= 1'b1;
         wdata_reg  <= s_axi_wdata_i;
         wstrb_reg  <= s_axi_wstrb_i;
      end
      else if (wr_go)
         w_held_reg <= 1'b0;
   end

   // read-only registers accept writes silently; unmapped ones refuse
   always_ff @(posedge mclk_i)
   begin
      if (!reset_n_i)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= spsf_pkg::RESP_OKAY;
      end
      else if (wr_go)
      begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= rd_hit_f(aw_idx_reg) ? spsf_pkg::RESP_OKAY : spsf_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready_i)
         bvalid_reg <= 1'b0;
   end

   assign s_axi_bvalid_o = bvalid_reg;
   assign s_axi_bresp_o  = bresp_reg;

   // ------------------------------------------------------------
   // axi4-lite read path
   // ------------------------------------------------------------
   function automatic logic rd_hit_f(input logic [6:0] idx);
      rd_hit_f = idx == spsf_pkg::IDX_PORT0_TO4_STATUS || idx == spsf_pkg::IDX_PORT5_STATUS
              || idx == spsf_pkg::IDX_CABLE_FAULT_STATUS || idx == spsf_pkg::IDX_RX_COUNTER_OVF
              || idx == spsf_pkg::IDX_TX_COUNTER_OVF || idx == spsf_pkg::IDX_IRQ_STATUS
              || idx == spsf_pkg::IDX_IRQ_MASK;
   endfunction : rd_hit_f

   assign s_axi_arready_o = !rvalid_reg;
   assign ar_take         = s_axi_arvalid_i && !rvalid_reg;
   assign ar_idx          = s_axi_araddr_i[8:2];
   assign rd_hit          = rd_hit_f(ar_idx);

   // read mux; unmapped words return zero
   always_comb
   begin
      rd_word = spsf_pkg::RESET_WORD;
      unique case (ar_idx)
         spsf_pkg::IDX_PORT0_TO4_STATUS:   rd_word = port04_word;
         spsf_pkg::IDX_PORT5_STATUS:       rd_word = port5_word;
         spsf_pkg::IDX_CABLE_FAULT_STATUS: rd_word = cable_word;
         spsf_pkg::IDX_RX_COUNTER_OVF:     rd_word = rx_ovf_reg;
         spsf_pkg::IDX_TX_COUNTER_OVF:     rd_word = tx_ovf_reg;
         spsf_pkg::IDX_IRQ_STATUS:         rd_word[spsf_pkg::IRQ_BITS-1:0] = irq_status_reg;
         spsf_pkg::IDX_IRQ_MASK:           rd_word[spsf_pkg::IRQ_BITS-1:0] = irq_mask_reg;
         default:                          rd_word = spsf_pkg::RESET_WORD;
      endcase
   end

   always_ff @(posedge mclk_i)
   begin
      if (!reset_n_i)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= spsf_pkg::RESET_WORD;
         rresp_reg  <= spsf_pkg::RESP_OKAY;
         rd_idx_reg <= '0;
      end
      else if (ar_take)
      begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= rd_word;
         rresp_reg  <= rd_hit ? spsf_pkg::RESP_OKAY : spsf_pkg::RESP_SLVERR;
         rd_idx_reg <= ar_idx;
      end
      else if (s_axi_rready_i)
         rvalid_reg <= 1'b0;
   end

   assign s_axi_rvalid_o = rvalid_reg;
   assign s_axi_rdata_o  = rdata_reg;
   assign s_axi_rresp_o  = rresp_reg;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_port0_fields;
      @(posedge mclk_i) disable iff (!reset_n_i)
      ar_take && ar_idx == spsf_pkg::IDX_PORT0_TO4_STATUS |=>
         s_axi_rdata_o[3:0] == $past({status_reg[0].flow, status_reg[0].duplex,
                                      status_reg[0].speed, status_reg[0].link});
   endproperty
   a_port0_fields: assert property (p_port0_fields) else $error("port 0 status bits wrong");

   property p_port0_link_seen;
      @(posedge mclk_i) disable iff (!reset_n_i)
      ports_i[0].link ##1 (ar_take && ar_idx == spsf_pkg::IDX_PORT0_TO4_STATUS)
         |=> s_axi_rdata_o[0];
   endproperty
   a_port0_link_seen: assert property (p_port0_link_seen) else $error("port 0 link lost");

   property p_port5_word;
      @(posedge mclk_i) disable iff (!reset_n_i)
      s_axi_rvalid_o && rd_idx_reg == spsf_pkg::IDX_PORT5_STATUS |->
         s_axi_rdata_o[31:5] == '0 && !s_axi_rdata_o[2];
   endproperty
   a_port5_word: assert property (p_port5_word) else $error("port 5 reserved or speed bad");

   property p_cable_reserved;
      @(posedge mclk_i) disable iff (!reset_n_i)
      s_axi_rvalid_o && rd_idx_reg == spsf_pkg::IDX_CABLE_FAULT_STATUS |->
         s_axi_rdata_o[31:24] == '0;
   endproperty
   a_cable_reserved: assert property (p_cable_reserved) else $error("cable reserved set");

   property p_rx_pkt_wrap;
      @(posedge mclk_i) disable iff (!reset_n_i)
      wrap_i.rx_pkt[5] |=> rx_ovf_reg[spsf_pkg::OVF_PKT_POS[5]];
   endproperty
   a_rx_pkt_wrap: assert property (p_rx_pkt_wrap) else $error("rx packet flag missed");

   property p_tx_byte_wrap;
      @(posedge mclk_i) disable iff (!reset_n_i)
      wrap_i.tx_byte[0] |=> tx_ovf_reg[spsf_pkg::OVF_BYTE_POS[0]];
   endproperty
   a_tx_byte_wrap: assert property (p_tx_byte_wrap) else $error("tx byte flag missed");

   property p_rx_clear;
      @(posedge mclk_i) disable iff (!reset_n_i)
      ar_take && ar_idx == spsf_pkg::IDX_RX_COUNTER_OVF && wrap_i == '0 |=>
         rx_ovf_reg == '0 && s_axi_rdata_o == $past(rx_ovf_reg);
   endproperty
   a_rx_clear: assert property (p_rx_clear) else $error("rx flags not cleared on read");

   property p_ovf_reserved;
      @(posedge mclk_i) disable iff (!reset_n_i)
      rx_ovf_reg[31:18] == '0 && tx_ovf_reg[31:18] == '0;
   endproperty
   a_ovf_reserved: assert property (p_ovf_reserved) else $error("overflow reserved set");

   property p_flag_holds;
      @(posedge mclk_i) disable iff (!reset_n_i)
      tx_ovf_reg[spsf_pkg::OVF_PKT_POS[2]] && !(ar_take && ar_idx == spsf_pkg::IDX_TX_COUNTER_OVF)
         |=> tx_ovf_reg[spsf_pkg::OVF_PKT_POS[2]];
   endproperty
   a_flag_holds: assert property (p_flag_holds) else $error("tx flag dropped");

   c_read_ovf: cover property (@(posedge mclk_i) ar_take && ar_idx == spsf_pkg::IDX_RX_COUNTER_OVF
                               && rx_ovf_reg != '0);
   c_clear_race: cover property (@(posedge mclk_i) ar_take && |rx_set
                                 && ar_idx == spsf_pkg::IDX_RX_COUNTER_OVF);
   c_irq: cover property (@(posedge mclk_i) $rose(irq_o));
   c_write_mask: cover property (@(posedge mclk_i) wr_go && aw_idx_reg == spsf_pkg::IDX_IRQ_MASK);

endmodule : spsf_regs

// ### common/spsf_pkg.sv
// constants and types of the switch port status flag register bank
//
// Operation
// - port 0 link state at bit 0
// - port 0 speed at bit 1, one=100Mb/s
// - port 0 duplex at bit 2, one=full
// - port 0 flow control active at bit 3
// - port 5 flow, duplex, link; 31:5 zero
// - port 5 speed two bits, 01=100Mb/s
// - cable broken bits 2,8,14,20,23; 31:24 zero
// - cable break distance fields per port 0..4
// - receive packet counter overflow flags per port
// - receive byte counter overflow flags; 31:18 reserved
// - transmit packet counter overflow flags per port
// - transmit byte counter overflow flags per port
// - overflow flags latch, clear on read
package spsf_pkg;

   // ------------------------------------------------------------
   // register indices; byte address is four times the index
   // ------------------------------------------------------------
   localparam logic [6:0] IDX_PORT0_TO4_STATUS   = 7'h01;
   localparam logic [6:0] IDX_PORT5_STATUS       = 7'h02;
   localparam logic [6:0] IDX_CABLE_FAULT_STATUS = 7'h03;
   localparam logic [6:0] IDX_RX_COUNTER_OVF     = 7'h3a;
   localparam logic [6:0] IDX_TX_COUNTER_OVF     = 7'h3b;
   localparam logic [6:0] IDX_IRQ_STATUS         = 7'h40;
   localparam logic [6:0] IDX_IRQ_MASK           = 7'h41;

   // ------------------------------------------------------------
   // field layout
   // ------------------------------------------------------------
   localparam int NUM_PORTS      = 6;
   localparam int NUM_CABLE      = 5;
   localparam int PORT_BASE[5]   = '{0, 8, 16, 24, 28};
   localparam int LINK_OFS       = 0;
   localparam int SPEED_OFS      = 1;
   localparam int DUPLEX_OFS     = 2;
   localparam int FLOW_OFS       = 3;
   localparam int P5_LINK_POS    = 0;
   localparam int P5_SPEED_LSB   = 1;
   localparam int P5_DUPLEX_POS  = 3;
   localparam int P5_FLOW_POS    = 4;
   localparam int BROKEN_POS[5]  = '{2, 8, 14, 20, 23};
   localparam int LEN_LSB[5]     = '{0, 6, 12, 18, 21};
   localparam int OVF_PKT_POS[6] = '{0, 2, 4, 6, 7, 8};
   localparam int OVF_BYTE_POS[6] = '{9, 11, 13, 15, 16, 17};

   // interrupt status bits
   localparam int IRQ_RX_OVF     = 0;
   localparam int IRQ_TX_OVF     = 1;
   localparam int IRQ_CABLE      = 2;
   localparam int IRQ_LINK       = 3;
   localparam int IRQ_BITS       = 4;

   // ------------------------------------------------------------
   // reset values and responses
   // ------------------------------------------------------------
   localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic       flow;
      logic       duplex;
      logic       speed;
      logic       link;
      logic       broken;
      logic [1:0] break_len;
   } spsf_port_t;

   typedef struct packed {
      logic [5:0] rx_pkt;
      logic [5:0] rx_byte;
      logic [5:0] tx_pkt;
      logic [5:0] tx_byte;
   } spsf_wrap_t;

endpackage : spsf_pkg

// ### bench/tb_top.sv
// self-checking testbench of the switch port status flag register bank
`timescale 1ns/1ps
module tb_top;

   // ------------------------------------------------------------
   // signals and state
   // ------------------------------------------------------------
   logic                 mclk_i;
   logic                 reset_n_i;
   spsf_pkg::spsf_port_t ports [6];
   spsf_pkg::spsf_wrap_t wrap;
   logic [8:0]           awaddr;
   logic                 awvalid;
   logic                 awready;
   logic [31:0]          wdata;
   logic [3:0]           wstrb;
   logic                 wvalid;
   logic                 wready;
   logic [1:0]           bresp;
   logic                 bvalid;
   logic                 bready;
   logic [8:0]           araddr;
   logic                 arvalid;
   logic                 arready;
   logic [31:0]          rdata;
   logic [1:0]           rresp;
   logic                 rvalid;
   logic                 rready;
   logic                 irq;
   int                   bad_count;
   int                   checks_done;
   logic [31:0]          seed;
   logic [31:0]          rd;
   logic [1:0]           rsp;
   logic [23:0]          acc;
   logic [6:0]           idx_tab [7];

   spsf_regs u_spsf_regs
   (
      .mclk_i          (mclk_i),
      .reset_n_i       (reset_n_i),
      .ports_i         (ports),
      .wrap_i          (wrap),
      .s_axi_awaddr_i  (awaddr),
      .s_axi_awvalid_i (awvalid),
      .s_axi_awready_o (awready),
      .s_axi_wdata_i   (wdata),
      .s_axi_wstrb_i   (wstrb),
      .s_axi_wvalid_i  (wvalid),
      .s_axi_wready_o  (wready),
      .s_axi_bresp_o   (bresp),
      .s_axi_bvalid_o  (bvalid),
      .s_axi_bready_i  (bready),
      .s_axi_araddr_i  (araddr),
      .s_axi_arvalid_i (arvalid),
      .s_axi_arready_o (arready),
      .s_axi_rdata_o   (rdata),
      .s_axi_rresp_o   (rresp),
      .s_axi_rvalid_o  (rvalid),
      .s_axi_rready_i  (rready),
      .irq_o           (irq)
   );

   // ------------------------------------------------------------
   // helpers: random source, expectations, comparison
   // ------------------------------------------------------------
   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   function logic [8:0] ad(input logic [6:0] idx);
      return {idx, 2'b00};
   endfunction : ad

   function logic [31:0] exp_p04();
      logic [31:0] w;
      w = '0;
      for (int p = 0; p < 5; p++)
      begin
         w[spsf_pkg::PORT_BASE[p] + 0] = ports[p].link;
         w[spsf_pkg::PORT_BASE[p] + 1] = ports[p].speed;
         w[spsf_pkg::PORT_BASE[p] + 2] = ports[p].duplex;
         w[spsf_pkg::PORT_BASE[p] + 3] = ports[p].flow;
      end
      return w;
   endfunction : exp_p04

   function logic [31:0] exp_p5();
      return {27'h0, ports[5].flow, ports[5].duplex, 1'b0, ports[5].speed, ports[5].link};
   endfunction : exp_p5

   function logic [31:0] exp_cable();
      logic [31:0] w;
      w = '0;
      for (int p = 0; p < 5; p++)
      begin
         w[spsf_pkg::BROKEN_POS[p]]          = ports[p].broken;
         w[spsf_pkg::LEN_LSB[p] +: 2]        = ports[p].break_len;
      end
      return w;
   endfunction : exp_cable

   // pkt and byte flags of one direction
   function logic [31:0] exp_ovf(input logic [5:0] pkt, input logic [5:0] byt);
      logic [31:0] w;
      w = '0;
      for (int p = 0; p < 6; p++)
      begin
         w[spsf_pkg::OVF_PKT_POS[p]]  = pkt[p];
         w[spsf_pkg::OVF_BYTE_POS[p]] = byt[p];
      end
      return w;
   endfunction : exp_ovf

   task check(input logic [31:0] seen, input logic [31:0] expv);
      checks_done++;
      if (seen !== expv)
      begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask : check

   // ------------------------------------------------------------
   // axi4-lite master; handshakes sampled at the rising edge itself
   // ------------------------------------------------------------
   // values read right after the edge are the ones the design sampled
   task axi_read(input logic [8:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge mclk_i);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge mclk_i); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge mclk_i); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axi_read

   // each channel is released at the edge that takes it; only the watchdog ends a wait
   task axi_write(input logic [8:0] a, input logic [31:0] d, output logic [1:0] r);
      logic a_t;
      logic w_t;
      a_t = 1'b0;
      w_t = 1'b0;
      @(posedge mclk_i);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= 4'hf;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do
      begin
         @(posedge mclk_i);
         a_t = a_t || (awready === 1'b1);
         w_t = w_t || (wready === 1'b1);
         if (a_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
      end
      while (!(a_t && w_t));
      do @(posedge mclk_i); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : axi_write

   // one-cycle wrap pulse
   task pulse(input logic [23:0] v);
      @(posedge mclk_i);
      wrap <= v;
      @(posedge mclk_i);
      wrap <= '0;
   endtask : pulse

   task conclude();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : conclude

   // ------------------------------------------------------------
   // clock, watchdog, main sequence
   // ------------------------------------------------------------
   initial
   begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end

   // whole run needs a few hundred cycles; generous margin
   initial
   begin
      repeat (20000) @(posedge mclk_i);
      bad_count++;
      conclude();
   end

   initial
   begin
      seed = 32'd80; bad_count = 0; checks_done = 0;
      reset_n_i = 1'b0; wrap = '0; awaddr = '0; awvalid = 1'b0; wdata = '0;
      wstrb = '0; wvalid = 1'b0; bready = 1'b0; araddr = '0; arvalid = 1'b0;
      rready = 1'b0;
      for (int p = 0; p < 6; p++) ports[p] = '0;
      idx_tab = '{spsf_pkg::IDX_PORT0_TO4_STATUS, spsf_pkg::IDX_PORT5_STATUS,
                  spsf_pkg::IDX_CABLE_FAULT_STATUS, spsf_pkg::IDX_RX_COUNTER_OVF,
                  spsf_pkg::IDX_TX_COUNTER_OVF, spsf_pkg::IDX_IRQ_STATUS,
                  spsf_pkg::IDX_IRQ_MASK};
      repeat (8) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      // reset values of every register
      foreach (idx_tab[i])
      begin
         axi_read(ad(idx_tab[i]), rd, rsp);
         check(rd, spsf_pkg::RESET_WORD);
      end
      $display("test reset values done");
      // random port status, all ones corner first
      for (int k = 0; k < 10; k++)
      begin
         @(posedge mclk_i);
         for (int p = 0; p < 6; p++) ports[p] <= (k == 0) ? 7'h7f : 7'(xs());
         repeat (3) @(posedge mclk_i);
         axi_read(ad(spsf_pkg::IDX_PORT0_TO4_STATUS), rd, rsp);
         check(rd, exp_p04());
         axi_read(ad(spsf_pkg::IDX_PORT5_STATUS), rd, rsp);
         check(rd, exp_p5());
         axi_read(ad(spsf_pkg::IDX_CABLE_FAULT_STATUS), rd, rsp);
         check(rd, exp_cable());
      end
      $display("test port status done");
      // overflow flags latch, accumulate, clear on read
      for (int k = 0; k < 6; k++)
      begin
         acc = (k == 0) ? 24'hffffff : 24'(xs());
         pulse(acc);
         pulse(acc ^ 24'h555555);
         acc = acc | (acc ^ 24'h555555);
         repeat (3) @(posedge mclk_i);
         axi_read(ad(spsf_pkg::IDX_RX_COUNTER_OVF), rd, rsp);
         check(rd, exp_ovf(acc[23:18], acc[17:12]));
         axi_read(ad(spsf_pkg::IDX_TX_COUNTER_OVF), rd, rsp);
         check(rd, exp_ovf(acc[11:6], acc[5:0]));
         axi_read(ad(spsf_pkg::IDX_RX_COUNTER_OVF), rd, rsp);
         check(rd, 32'h0);
         axi_read(ad(spsf_pkg::IDX_TX_COUNTER_OVF), rd, rsp);
         check(rd, 32'h0);
      end
      $display("test overflow flags done");
      // interrupt: masked event, unmask, clear by read
      axi_read(ad(spsf_pkg::IDX_IRQ_STATUS), rd, rsp);
      pulse(24'h040000);
      repeat (3) @(posedge mclk_i);
      @(negedge mclk_i);
      check({31'h0, irq}, 32'h0);
      axi_write(ad(spsf_pkg::IDX_IRQ_MASK), 32'h3, rsp);
      repeat (2) @(negedge mclk_i);
      check({31'h0, irq}, 32'h1);
      axi_read(ad(spsf_pkg::IDX_IRQ_MASK), rd, rsp);
      check(rd, 32'h3);
      axi_read(ad(spsf_pkg::IDX_IRQ_STATUS), rd, rsp);
      check(rd, 32'h1);
      repeat (2) @(negedge mclk_i);
      check({31'h0, irq}, 32'h0);
      axi_read(ad(spsf_pkg::IDX_RX_COUNTER_OVF), rd, rsp);
      check(rd, exp_ovf(6'h01, 6'h00));
      $display("test interrupt done");
      // read-only write ignored, unmapped refused
      axi_write(ad(spsf_pkg::IDX_PORT5_STATUS), 32'hffffffff, rsp);
      check({30'h0, rsp}, {30'h0, spsf_pkg::RESP_OKAY});
      axi_read(ad(spsf_pkg::IDX_PORT5_STATUS), rd, rsp);
      check(rd, exp_p5());
      axi_write(9'h010, 32'h1, rsp);
      check({30'h0, rsp}, {30'h0, spsf_pkg::RESP_SLVERR});
      axi_read(9'h010, rd, rsp);
      check({30'h0, rsp}, {30'h0, spsf_pkg::RESP_SLVERR});
      check(rd, 32'h0);
      $display("test bus errors done");
      conclude();
   end

endmodule : tb_top
